// ### rtl/aaf_core.sv
// accumulator arithmetic datapath with flags behind an axi4-lite slave
`timescale 1ns/1ns
`include "aaf_params.svh"
module aaf_core import aaf_pkg::*; #(
	parameter int ADDR_W = 12,
	parameter int RAM_DEPTH = 64
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [7:0] acc_value,
	output logic [7:0] second_operand_value,
	output logic carry_flag,
	output logic half_carry_flag,
	output logic signed_range_flag,
	output logic branch_taken,
	output logic busy
);
	localparam int RAM_AW = $clog2(RAM_DEPTH);

	// =============================================================
	// elaboration checks
	initial begin
		if (ADDR_W != 12) begin
			$error("aaf_core: ADDR_W must be 12");
		end
		if (RAM_DEPTH < 8 || RAM_DEPTH > 64 || (1 << RAM_AW) != RAM_DEPTH) begin
			$error("aaf_core: RAM_DEPTH must be a power of two from 8 to 64");
		end
	end

	// =============================================================
	// arithmetic functions, result packed as {cy, ac, ov, value}
	function automatic logic [10:0] alu_add(input logic [7:0] a, input logic [7:0] b,
		input logic cin);
		logic [4:0] lo;
		logic [7:0] mid;
		logic [8:0] full;
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		mid = {1'b0, a[6:0]} + {1'b0, b[6:0]} + {7'h00, cin};
		full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		// carry out, nibble carry, bit-7 xor bit-6 carry
		return {full[8], lo[4], full[8] ^ mid[7], full[7:0]};
	endfunction

	function automatic logic [10:0] alu_sub(input logic [7:0] a, input logic [7:0] b,
		input logic bin);
		logic [4:0] lo;
		logic [7:0] mid;
		logic [8:0] full;
		lo = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, bin};
		mid = {1'b0, a[6:0]} - {1'b0, b[6:0]} - {7'h00, bin};
		full = {1'b0, a} - {1'b0, b} - {8'h00, bin};
		// borrow out of bit 7, borrow for bit 3, xor of borrows out of 7 and 6
		return {full[8], lo[4], full[8] ^ mid[7], full[7:0]};
	endfunction

	function automatic logic is_ram(input logic [ADDR_W-1:0] addr);
		return addr[11:8] == `AAF_RAM_PAGE;
	endfunction

	// =============================================================
	// state
	aaf_state_e state;
	aaf_op_t cmd_op;
	aaf_src_t cmd_src;
	logic [7:0] cmd_opnd;
	logic [7:0] ram_rdata;
	logic [ADDR_W-1:0] rd_addr;

	// =============================================================
	// handshake decode
	logic wr_fire;
	logic rd_fire;
	logic wr_ok;
	logic cmd_fire;
	logic ram_we;
	logic ram_re;
	logic [RAM_AW-1:0] ram_raddr;
	logic exec_now;
	logic [7:0] operand;
	logic [10:0] add_res;
	logic [10:0] sub_res;
	logic [15:0] product;
	logic acc_zero;

	assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	// only the low byte lane strobe gates a write; command writes also take byte 1
	assign wr_ok = wr_fire && s_axi_wstrb[0];
	assign cmd_fire = wr_ok && s_axi_awaddr == `AAF_CMD_OFF;
	assign ram_we = wr_ok && is_ram(s_axi_awaddr);
	assign exec_now = state == st_exec;

	// ram read port: operand fetch for a command, else a bus read
	always_comb begin
		ram_re = 1'b0;
		ram_raddr = '0;
		if (cmd_fire) begin
			ram_re = 1'b1;
			if (s_axi_wdata[`AAF_CMD_SRC_LSB +: 2] == `AAF_SRC_WREG) begin
				ram_raddr = RAM_AW'(s_axi_wdata[`AAF_CMD_OPND_LSB +: 3]);
			end else begin
				ram_raddr = s_axi_wdata[`AAF_CMD_OPND_LSB +: RAM_AW];
			end
		end else if (rd_fire && is_ram(s_axi_araddr)) begin
			ram_re = 1'b1;
			ram_raddr = s_axi_araddr[2 +: RAM_AW];
		end
	end

	// operand select and arithmetic results
	assign operand = (cmd_src == `AAF_SRC_DIRECT || cmd_src == `AAF_SRC_WREG) ?
		ram_rdata : cmd_opnd;
	assign add_res = alu_add(acc_value, operand,
		(cmd_op == `AAF_OP_SUM_WITH_CARRY) ? carry_flag : 1'b0);
	assign sub_res = alu_sub(acc_value, operand, carry_flag);
	assign product = 16'(acc_value * second_operand_value);
	assign acc_zero = acc_value == 8'h00;

	aaf_opram #(
		.DEPTH(RAM_DEPTH),
		.AW(RAM_AW)
	) u_opram (
		.aclk(aclk),
		.ce(ce),
		.we(ram_we),
		.waddr(s_axi_awaddr[2 +: RAM_AW]),
		.wdata(s_axi_wdata[7:0]),
		.re(ram_re),
		.raddr(ram_raddr),
		.rdata(ram_rdata)
	);

	// =============================================================
	// sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= st_idle;
		end else if (ce) begin
			case (state)
				st_idle: begin
					if (cmd_fire) begin
						state <= st_exec;
					end else if (rd_fire && is_ram(s_axi_araddr)) begin
						state <= st_rdmem;
					end
				end
				st_exec: state <= st_idle;
				st_rdmem: state <= st_idle;
				default: state <= st_idle;
			endcase
		end
	end

	// command latch
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cmd_op <= `AAF_OP_ADD;
			cmd_src <= `AAF_SRC_IMM;
			cmd_opnd <= 8'h00;
		end else if (ce && cmd_fire) begin
			cmd_op <= s_axi_wdata[`AAF_CMD_OP_LSB +: 3];
			cmd_src <= s_axi_wdata[`AAF_CMD_SRC_LSB +: 2];
			cmd_opnd <= s_axi_wdata[`AAF_CMD_OPND_LSB +: 8];
		end
	end

	// busy mirrors a command or ram bus read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'b0;
		end else if (ce) begin
			busy <= cmd_fire || (rd_fire && is_ram(s_axi_araddr));
		end
	end

	// =============================================================
	// accumulator: software write or operation result
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_value <= `AAF_ACC_RST;
		end else if (ce) begin
			if (exec_now) begin
				case (cmd_op)
					`AAF_OP_ADD, `AAF_OP_SUM_WITH_CARRY: acc_value <= add_res[7:0];
					`AAF_OP_DIFFERENCE_WITH_BORROW: acc_value <= sub_res[7:0];
					`AAF_OP_MUL: acc_value <= product[7:0];
					default: acc_value <= acc_value;
				endcase
			end else if (wr_ok && s_axi_awaddr == `AAF_ACC_OFF) begin
				acc_value <= s_axi_wdata[7:0];
			end
		end
	end

	// second operand register: software write or high product byte
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			second_operand_value <= `AAF_SECOND_RST;
		end else if (ce) begin
			if (exec_now && cmd_op == `AAF_OP_MUL) begin
				second_operand_value <= product[15:8];
			end else if (wr_ok && s_axi_awaddr == `AAF_SECOND_OFF) begin
				second_operand_value <= s_axi_wdata[7:0];
			end
		end
	end

	// flags: software write or operation result
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			{signed_range_flag, half_carry_flag, carry_flag} <= `AAF_FLAGS_RST;
		end else if (ce) begin
			if (exec_now) begin
				case (cmd_op)
					`AAF_OP_ADD, `AAF_OP_SUM_WITH_CARRY: begin
						carry_flag <= add_res[10];
						half_carry_flag <= add_res[9];
						signed_range_flag <= add_res[8];
					end
					`AAF_OP_DIFFERENCE_WITH_BORROW: begin
						carry_flag <= sub_res[10];
						half_carry_flag <= sub_res[9];
						signed_range_flag <= sub_res[8];
					end
					`AAF_OP_MUL: begin
						carry_flag <= 1'b0;
						signed_range_flag <= product[15:8] != 8'h00;
					end
					default: carry_flag <= carry_flag;
				endcase
			end else if (wr_ok && s_axi_awaddr == `AAF_FLAGS_OFF) begin
				carry_flag <= s_axi_wdata[`AAF_FLG_CY];
				half_carry_flag <= s_axi_wdata[`AAF_FLG_AC];
				signed_range_flag <= s_axi_wdata[`AAF_FLG_OV];
			end
		end
	end

	// branch decision straight from the accumulator value
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			branch_taken <= 1'b0;
		end else if (ce && exec_now) begin
			if (cmd_op == `AAF_OP_JZ) begin
				branch_taken <= acc_zero;
			end else if (cmd_op == `AAF_OP_JNZ) begin
				branch_taken <= !acc_zero;
			end
		end
	end

	// =============================================================
	// write channels: both ready together once address and data wait
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else if (ce) begin
			if (s_axi_awready) begin
				s_axi_awready <= 1'b0;
				s_axi_wready <= 1'b0;
			end else if (state == st_idle && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid &&
				!s_axi_arready) begin
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// write response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AAF_RESP_OKAY;
		end else if (ce) begin
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				if (s_axi_awaddr == `AAF_ACC_OFF || s_axi_awaddr == `AAF_FLAGS_OFF ||
					s_axi_awaddr == `AAF_CMD_OFF || s_axi_awaddr == `AAF_STAT_OFF ||
					s_axi_awaddr == `AAF_SECOND_OFF || is_ram(s_axi_awaddr)) begin
					s_axi_bresp <= `AAF_RESP_OKAY;
				end else begin
					s_axi_bresp <= `AAF_RESP_SLVERR;
				end
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// =============================================================
	// read address channel, writes win when both wait
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
		end else if (ce) begin
			if (s_axi_arready) begin
				s_axi_arready <= 1'b0;
			end else if (state == st_idle && s_axi_arvalid && !s_axi_rvalid &&
				!(s_axi_awvalid && s_axi_wvalid) && !s_axi_awready) begin
				s_axi_arready <= 1'b1;
			end
		end
	end

	// read address hold; nothing reads it, the ram path takes s_axi_araddr at the handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rd_addr <= '0;
		end else if (ce && rd_fire) begin
			rd_addr <= s_axi_araddr;
		end
	end

	// read data: registers answer next cycle, ram one cycle later
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `AAF_RESP_OKAY;
		end else if (ce) begin
			if (state == st_rdmem) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, ram_rdata};
				s_axi_rresp <= `AAF_RESP_OKAY;
			end else if (rd_fire && !is_ram(s_axi_araddr)) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= `AAF_RESP_OKAY;
				case (s_axi_araddr)
					`AAF_ACC_OFF: s_axi_rdata <= {24'h000000, acc_value};
					`AAF_FLAGS_OFF: s_axi_rdata <= {29'h00000000, signed_range_flag,
						half_carry_flag, carry_flag};
					`AAF_CMD_OFF: s_axi_rdata <= {16'h0000, cmd_opnd, 2'h0, cmd_src,
						1'b0, cmd_op};
					`AAF_STAT_OFF: s_axi_rdata <= {29'h00000000, acc_zero, branch_taken,
						busy};
					`AAF_SECOND_OFF: s_axi_rdata <= {24'h000000, second_operand_value};
					default: begin
						s_axi_rdata <= 32'h00000000;
						s_axi_rresp <= `AAF_RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule

// ### rtl/aaf_opram.sv
// operand memory: internal ram bytes, working registers at the bottom
`timescale 1ns/1ns
module aaf_opram import aaf_pkg::*; #(
	parameter int DEPTH = 64,
	parameter int AW = 6
) (
	input wire logic aclk,
	input wire logic ce,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic re,
	input wire logic [AW-1:0] raddr,
	output logic [7:0] rdata
);
	// =============================================================
	// storage
	logic [7:0] mem [DEPTH];

	// write port
	always_ff @(posedge aclk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read port
	always_ff @(posedge aclk) begin
		if (ce && re) begin
			rdata <= mem[raddr];
		end
	end
endmodule

// ### rtl/aaf_params.svh
// offsets, field positions, reset values and codes of the accumulator datapath
`ifndef AAF_PARAMS_SVH
`define AAF_PARAMS_SVH
// =============================================================
// register byte offsets
`define AAF_ACC_OFF 12'h000
`define AAF_FLAGS_OFF 12'h004
`define AAF_CMD_OFF 12'h008
`define AAF_STAT_OFF 12'h00C
`define AAF_SECOND_OFF 12'h0F0
`define AAF_RAM_PAGE 4'h1
// =============================================================
// flag register fields
`define AAF_FLG_CY 0
`define AAF_FLG_AC 1
`define AAF_FLG_OV 2
// =============================================================
// command register fields
`define AAF_CMD_OP_LSB 0
`define AAF_CMD_SRC_LSB 4
`define AAF_CMD_OPND_LSB 8
// =============================================================
// status register fields
`define AAF_STAT_BUSY 0
`define AAF_STAT_TAKEN 1
`define AAF_STAT_ZERO 2
// =============================================================
// operation and operand source codes
`define AAF_OP_ADD 3'h0
`define AAF_OP_SUM_WITH_CARRY 3'h1
`define AAF_OP_DIFFERENCE_WITH_BORROW 3'h2
`define AAF_OP_MUL 3'h3
`define AAF_OP_JZ 3'h4
`define AAF_OP_JNZ 3'h5
`define AAF_SRC_IMM 2'h0
`define AAF_SRC_DIRECT 2'h1
`define AAF_SRC_WREG 2'h2
// =============================================================
// reset values and bus responses
`define AAF_ACC_RST 8'h00
`define AAF_SECOND_RST 8'h00
`define AAF_FLAGS_RST 3'h0
`define AAF_RESP_OKAY 2'h0
`define AAF_RESP_SLVERR 2'h2
`endif

// ### rtl/aaf_pkg.sv
// types shared by the accumulator datapath files
package aaf_pkg;
	// =============================================================
	// types
	typedef enum logic [1:0] {st_idle, st_exec, st_rdmem} aaf_state_e;
	typedef logic [2:0] aaf_op_t;
	typedef logic [1:0] aaf_src_t;
endpackage

// ### tb/aaf_core_sva.sv
// assertion checker on the accumulator datapath ports
`timescale 1ns/1ns
`include "aaf_params.svh"
module aaf_core_sva import aaf_pkg::*; #(
	parameter int ADDR_W = 12
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [7:0] acc_value,
	input wire logic [7:0] second_operand_value,
	input wire logic carry_flag,
	input wire logic half_carry_flag,
	input wire logic signed_range_flag,
	input wire logic branch_taken
);
	// ==========
	// command capture
	aaf_op_t op;
	logic [1:0] pend;
	logic [7:0] a, b, m;
	logic im, c, h, ci, whs;
	logic [8:0] s9, d9;
	logic [7:0] s8, d8;
	logic [4:0] s5, d5;
	logic [15:0] p;
	assign whs = s_axi_awvalid & s_axi_awready & s_axi_wvalid & s_axi_wready;
	// command pipeline, two edges deep
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pend <= 2'h0;
		end else begin
			pend <= {pend[0], whs & s_axi_wstrb[0] & (s_axi_awaddr == ADDR_W'(`AAF_CMD_OFF))};
		end
	end
	// operands as they stood at the command write
	always_ff @(posedge aclk) begin
		if (whs) begin
			{op, im, b} <= {s_axi_wdata[2:0], s_axi_wdata[4] == s_axi_wdata[5], s_axi_wdata[15:8]};
			{a, m, c, h} <= {acc_value, second_operand_value, carry_flag, half_carry_flag};
		end
	end
	// reference sums, differences and product
	assign ci = c & (op == `AAF_OP_SUM_WITH_CARRY || op == `AAF_OP_DIFFERENCE_WITH_BORROW);
	assign s9 = a + b + ci;
	assign s8 = a[6:0] + b[6:0] + ci;
	assign s5 = a[3:0] + b[3:0] + ci;
	assign d9 = a - b - ci;
	assign d8 = a[6:0] - b[6:0] - ci;
	assign d5 = a[3:0] - b[3:0] - ci;
	assign p = a * m;
	// ==========
	// assertions
	default clocking dc @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// command write, then the edge after its execute edge
	sequence s_cmd;
		whs ##2 pend[1];
	endsequence
	sequence s_add;
		s_cmd ##0 im && (op == `AAF_OP_ADD || op == `AAF_OP_SUM_WITH_CARRY);
	endsequence
	sequence s_sub;
		s_cmd ##0 im && op == `AAF_OP_DIFFERENCE_WITH_BORROW;
	endsequence
	a_add_result: assert property (s_add |-> {carry_flag, acc_value} == s9)
		else $error("add sum wrong");
	a_add_flags: assert property (s_add |-> half_carry_flag == s5[4]
		&& signed_range_flag == (s9[8] ^ s8[7])) else $error("add flags wrong");
	a_sub_result: assert property (s_sub |-> {carry_flag, acc_value} == d9)
		else $error("difference wrong");
	a_sub_flags: assert property (s_sub |-> half_carry_flag == d5[4]
		&& signed_range_flag == (d9[8] ^ d8[7])) else $error("subtract flags wrong");
	a_mul_result: assert property (s_cmd ##0 op == `AAF_OP_MUL |->
		{second_operand_value, acc_value} == p && !carry_flag && half_carry_flag == h
		&& signed_range_flag == (p > 16'h00FF)) else $error("product wrong");
	a_branch_live: assert property (s_cmd ##0
		(op == `AAF_OP_JZ || op == `AAF_OP_JNZ) |-> branch_taken == ((a == 8'h00)
		^ (op == `AAF_OP_JNZ))) else $error("branch test wrong");
	a_one_edge: assert property (s_cmd |-> $past(acc_value) == a
		&& $past(second_operand_value) == m && $past(carry_flag) == c) else $error("early update");
	a_write_resp: assert property (whs |=> s_axi_bvalid) else $error("no write response");
endmodule
bind aaf_core aaf_core_sva #(.ADDR_W(ADDR_W)) sva_u (.*);

// ### tb/tb_accumulator_alu_flags.sv
// self-checking bench for the accumulator datapath
`timescale 1ns/1ns
`include "aaf_params.svh"
module tb_accumulator_alu_flags import aaf_pkg::*; ;
	// ==========
	// signals
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic ce = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000;
	logic [11:0] s_axi_araddr = 12'h000;
	logic [2:0] s_axi_awprot = 3'h0;
	logic [2:0] s_axi_arprot = 3'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [31:0] s_axi_rdata, d;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic [7:0] acc_value, second_operand_value;
	logic carry_flag, half_carry_flag, signed_range_flag, branch_taken, busy;
	int n_mismatch = 0;
	int checked = 0;
	always #50 aclk = ~aclk;
	aaf_core dut_u (.*);
	// ==========
	// bus and compare tasks
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	// write: address and data offered together, each released when taken
	task automatic wr(input logic [11:0] ad, input logic [31:0] wd, output logic [1:0] rs);
		logic ra, rw, b;
		s_axi_awaddr <= ad;
		s_axi_wdata <= wd;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			{ra, rw, b, rs} = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp};
			@(posedge aclk);
			if (ra) s_axi_awvalid <= 1'b0;
			if (rw) s_axi_wvalid <= 1'b0;
		end while (!b);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [11:0] ad, output logic [31:0] rd_d, output logic [1:0] rs);
		logic ra, v;
		s_axi_araddr <= ad;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			{ra, v, rd_d, rs} = {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
			@(posedge aclk);
			if (ra) s_axi_arvalid <= 1'b0;
		end while (!v);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask
	// load operands and flags, run one command, compare all results
	task automatic op_run(input logic [7:0] a, b, input logic [2:0] f, input logic [5:0] o,
		input logic [7:0] k, ea, eb, input logic [2:0] ef);
		wr(`AAF_ACC_OFF, {24'h0, a}, r);
		wr(`AAF_SECOND_OFF, {24'h0, b}, r);
		wr(`AAF_FLAGS_OFF, {29'h0, f}, r);
		wr(`AAF_CMD_OFF, {16'h0, k, 2'h0, o}, r);
		chk("cmd resp", {30'h0, `AAF_RESP_OKAY}, {30'h0, r});
		rd(`AAF_ACC_OFF, d, r);
		chk("acc", {24'h0, ea}, d);
		rd(`AAF_SECOND_OFF, d, r);
		chk("second", {24'h0, eb}, d);
		rd(`AAF_FLAGS_OFF, d, r);
		chk("flags", {29'h0, ef}, d);
		chk("acc pin", {24'h0, ea}, {24'h0, acc_value});
		chk("second pin", {24'h0, eb}, {24'h0, second_operand_value});
		chk("flag pins", {29'h0, ef}, {29'h0, signed_range_flag, half_carry_flag, carry_flag});
		chk("busy pin", 32'h0, {31'h0, busy});
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// ==========
	// scenarios
	task automatic t_reset();
		rd(`AAF_ACC_OFF, d, r);
		chk("acc reset", 32'h0, d);
		rd(`AAF_SECOND_OFF, d, r);
		chk("second reset", 32'h0, d);
		rd(12'h010, d, r);
		chk("unmapped read", {30'h0, `AAF_RESP_SLVERR}, {30'h0, r});
		$display("t_reset done");
	endtask
	task automatic t_add();
		op_run(8'hF0, 8'h07, 3'h0, `AAF_OP_ADD, 8'h20, 8'h10, 8'h07, 3'h1);
		op_run(8'h70, 8'h07, 3'h0, `AAF_OP_ADD, 8'h20, 8'h90, 8'h07, 3'h4);
		op_run(8'h01, 8'h07, 3'h1, `AAF_OP_ADD, 8'h01, 8'h02, 8'h07, 3'h0);
		op_run(8'h7F, 8'h07, 3'h1, `AAF_OP_SUM_WITH_CARRY, 8'h00, 8'h80, 8'h07, 3'h6);
		$display("t_add done");
	endtask
	task automatic t_sub();
		op_run(8'h38, 8'h07, 3'h1, `AAF_OP_DIFFERENCE_WITH_BORROW, 8'h06, 8'h31, 8'h07, 3'h0);
		op_run(8'h10, 8'h07, 3'h0, `AAF_OP_DIFFERENCE_WITH_BORROW, 8'h20, 8'hF0, 8'h07, 3'h1);
		op_run(8'h80, 8'h07, 3'h0, `AAF_OP_DIFFERENCE_WITH_BORROW, 8'h01, 8'h7F, 8'h07, 3'h6);
		$display("t_sub done");
	endtask
	task automatic t_mul();
		op_run(8'h20, 8'h75, 3'h3, `AAF_OP_MUL, 8'h00, 8'hA0, 8'h0E, 3'h6);
		op_run(8'h0F, 8'h11, 3'h1, `AAF_OP_MUL, 8'h00, 8'hFF, 8'h00, 3'h0);
		$display("t_mul done");
	endtask
	// both zero tests on zero and nonzero, then a live change
	task automatic t_branch();
		logic [7:0] a;
		for (int i = 0; i < 4; i++) begin
			a = i[0] ? 8'h5A : 8'h00;
			op_run(a, 8'h33, 3'h5, i[1] ? `AAF_OP_JNZ : `AAF_OP_JZ, 8'h00, a, 8'h33, 3'h5);
			rd(`AAF_STAT_OFF, d, r);
			chk("status", {29'h0, a == 8'h00, (a == 8'h00) ^ i[1], 1'b0}, d);
		end
		wr(`AAF_ACC_OFF, 32'h0, r);
		rd(`AAF_STAT_OFF, d, r);
		chk("live zero", 32'h6, d);
		chk("branch pin", 32'h1, {31'h0, branch_taken});
		$display("t_branch done");
	endtask
	// direct ram byte and working register as addend
	task automatic t_src();
		logic [5:0] o;
		wr(12'h114, 32'h11, r);
		wr(12'h194, 32'h40, r);
		o = {`AAF_SRC_DIRECT, 1'b0, `AAF_OP_ADD};
		op_run(8'h01, 8'h00, 3'h0, o, 8'h25, 8'h41, 8'h00, 3'h0);
		o = {`AAF_SRC_WREG, 1'b0, `AAF_OP_ADD};
		op_run(8'h01, 8'h00, 3'h0, o, 8'h0D, 8'h12, 8'h00, 3'h0);
		rd(12'h194, d, r);
		chk("ram read", 32'h40, d);
		chk("ram resp", {30'h0, `AAF_RESP_OKAY}, {30'h0, r});
		$display("t_src done");
	endtask
	// ==========
	// main sequence and watchdog
	initial begin
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_add();
		t_sub();
		t_mul();
		t_branch();
		t_src();
		stop_test();
	end
	initial begin
		#(2000 * 100);
		n_mismatch++;
		stop_test();
	end
endmodule
